// ===== core/rbhp_pkg.sv
// Package with constants and types for the byte-wide host port.
package rbhp_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int INDEX_W = 4;
	localparam int BYTE_W = 8;
	localparam int REG_COUNT = 16;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic PF_RESET = 1'b1;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_ACCESS_NS = 85;
	localparam int OE_ACCESS_NS = 35;
	localparam int WRITE_RELEASE_NS = 25;
	// Longest times round down, never below one cycle.
	localparam int ADDR_ACCESS_CYC = (ADDR_ACCESS_NS / CLK_PERIOD_NS < 1) ? 1 :
		ADDR_ACCESS_NS / CLK_PERIOD_NS;
	localparam int OE_ACCESS_CYC = (OE_ACCESS_NS / CLK_PERIOD_NS < 1) ? 1 :
		OE_ACCESS_NS / CLK_PERIOD_NS;
	localparam int WRITE_RELEASE_CYC =
		(WRITE_RELEASE_NS / CLK_PERIOD_NS < 1) ? 1 :
		WRITE_RELEASE_NS / CLK_PERIOD_NS;
	// Pin to output latency: three synchroniser stages plus the output flop.
	localparam int SYNC_STAGES = 3;
	localparam int PIN_LATENCY_CYC = SYNC_STAGES + 1;

	// ---------------------------------------------------------------
	// Cycle states
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} rbhp_state_t;

endpackage : rbhp_pkg

// ===== core/rbhp_sync.sv
// Three-stage pin synchroniser with agreement filter.
module rbhp_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Pin side
	input wire logic [WIDTH-1:0] d_i,
	// Clock side
	output logic [WIDTH-1:0] q_o
);

	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} rbhp_sync_state_t;

	rbhp_sync_state_t state_r;
	rbhp_sync_state_t state_nxt;

	// ---------------------------------------------------------------
	// Agreement
	// ---------------------------------------------------------------
	// The first stage feeds only the second; a bit changes only once the
	// second and third stages hold the same value.
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.s1 = d_i;
		state_nxt.s2 = state_r.s1;
		state_nxt.s3 = state_r.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (state_r.s2[i] == state_r.s3[i])
			begin
				state_nxt.q[i] = state_r.s3[i];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			state_r <= {INIT, INIT, INIT, INIT};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign q_o = state_r.q;

endmodule : rbhp_sync

// ===== core/rbhp_port.sv
// Byte-wide host port: register file, read/write decode and SRAM routing.
module rbhp_port
#(
	parameter int REG_COUNT = rbhp_pkg::REG_COUNT
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Host strobes, all active low
	input wire logic reg_select_n_i,
	input wire logic sram_select_n_i,
	input wire logic out_enable_n_i,
	input wire logic write_n_i,
	// Host address and data
	input wire logic [rbhp_pkg::INDEX_W-1:0] register_index_i,
	input wire logic [rbhp_pkg::BYTE_W-1:0] byte_lines_i,
	output logic [rbhp_pkg::BYTE_W-1:0] byte_lines_o,
	output logic byte_lines_oe_o,
	// Supply monitor, high while supply is below threshold
	input wire logic power_fail_i,
	// External SRAM strobes, active low
	output logic sram_bank_select_n_o,
	output logic sram_write_n_o,
	output logic sram_read_n_o
);

	// ---------------------------------------------------------------
	// Synchronised pins
	// ---------------------------------------------------------------
	logic sel_n;
	logic ext_n;
	logic oe_n;
	logic wr_n;
	logic pf;
	logic [rbhp_pkg::INDEX_W-1:0] idx;
	logic [rbhp_pkg::BYTE_W-1:0] din;

	// Strobes share one synchroniser so that their relative order is kept.
	rbhp_sync
	#(
		.WIDTH(5),
		.INIT({rbhp_pkg::STROBE_IDLE, rbhp_pkg::STROBE_IDLE,
			rbhp_pkg::STROBE_IDLE, rbhp_pkg::STROBE_IDLE,
			rbhp_pkg::PF_RESET})
	)
	u_sync_strobe
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({reg_select_n_i, sram_select_n_i, out_enable_n_i, write_n_i,
			power_fail_i}),
		.q_o({sel_n, ext_n, oe_n, wr_n, pf})
	);

	rbhp_sync
	#(
		.WIDTH(rbhp_pkg::INDEX_W + rbhp_pkg::BYTE_W),
		.INIT('0)
	)
	u_sync_bus
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({register_index_i, byte_lines_i}),
		.q_o({idx, din})
	);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed
	{
		rbhp_pkg::rbhp_state_t st;
		logic mute;
		logic [rbhp_pkg::INDEX_W-1:0] wr_idx;
		logic [rbhp_pkg::BYTE_W-1:0] wr_dat;
		logic [REG_COUNT-1:0][rbhp_pkg::BYTE_W-1:0] regs;
		logic [rbhp_pkg::BYTE_W-1:0] dout;
		logic oe;
		logic sram_sel_n;
		logic sram_wr_n;
		logic sram_rd_n;
	} rbhp_port_state_t;

	rbhp_port_state_t state_r;
	rbhp_port_state_t state_nxt;

	// Register-side access is live only with select low and no power fail.
	function automatic logic reg_access(input logic sel_n_f, input logic pf_f);
		reg_access = !sel_n_f && !pf_f;
	endfunction : reg_access

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic acc;
		logic commit;
		acc = 1'b0;
		commit = 1'b0;
		state_nxt = state_r;
		acc = reg_access(sel_n, pf);

		case (state_r.st)
			rbhp_pkg::ST_IDLE:
			begin
				state_nxt.mute = 1'b0;
				if (acc && wr_n)
				begin
					state_nxt.st = rbhp_pkg::ST_READ;
				end
				else if (acc)
				begin
					// Select found low with the strobe already low: the
					// bus stays released until select rises again or a power fail drops the access.
					state_nxt.st = rbhp_pkg::ST_WRITE;
					state_nxt.mute = 1'b1;
				end
			end
			rbhp_pkg::ST_READ:
			begin
				if (!acc)
				begin
					state_nxt.st = rbhp_pkg::ST_IDLE;
				end
				else if (!wr_n)
				begin
					// Write opens at the later of the two falls.
					state_nxt.st = rbhp_pkg::ST_WRITE;
				end
			end
			rbhp_pkg::ST_WRITE:
			begin
				if (!acc || wr_n)
				begin
					// Earlier rise of either strobe closes the write.
					commit = 1'b1;
					state_nxt.st = acc ? rbhp_pkg::ST_READ :
						rbhp_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_nxt.st = rbhp_pkg::ST_IDLE;
			end
		endcase

		// Keep the last index and byte seen while the write was open; the
		// host holds both up to the closing edge.
		if (state_r.st == rbhp_pkg::ST_WRITE && acc && !wr_n)
		begin
			state_nxt.wr_idx = idx;
			state_nxt.wr_dat = din;
		end
		else if (state_r.st != rbhp_pkg::ST_WRITE)
		begin
			state_nxt.wr_idx = idx;
			state_nxt.wr_dat = din;
		end

		// A power fail during a write aborts it without storing.
		if (commit && !pf)
		begin
			state_nxt.regs[state_r.wr_idx] = state_r.wr_dat;
		end

		// Read data follows the index every cycle.
		state_nxt.dout = state_nxt.regs[idx];

		state_nxt.oe = acc && !oe_n && wr_n &&
			state_nxt.st == rbhp_pkg::ST_READ && !state_nxt.mute;

		// External select is honoured only while register select is high;
		// it is forced high during a power fail.
		state_nxt.sram_sel_n = !(!ext_n && sel_n && !pf);
		state_nxt.sram_wr_n = state_nxt.sram_sel_n | wr_n;
		state_nxt.sram_rd_n = state_nxt.sram_sel_n | oe_n | !wr_n;
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			state_r.st <= rbhp_pkg::ST_IDLE;
			state_r.mute <= 1'b0;
			state_r.wr_idx <= '0;
			state_r.wr_dat <= '0;
			state_r.regs <= {REG_COUNT{rbhp_pkg::REG_RESET}};
			state_r.dout <= '0;
			state_r.oe <= 1'b0;
			state_r.sram_sel_n <= 1'b1;
			state_r.sram_wr_n <= 1'b1;
			state_r.sram_rd_n <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign byte_lines_o = state_r.dout;
	assign byte_lines_oe_o = state_r.oe;
	assign sram_bank_select_n_o = state_r.sram_sel_n;
	assign sram_write_n_o = state_r.sram_wr_n;
	assign sram_read_n_o = state_r.sram_rd_n;

endmodule : rbhp_port

// ===== bench/rbhp_port_monitor.sv
// Checker for the byte-wide host port pins.
module rbhp_port_monitor
#(
	parameter int REG_COUNT = rbhp_pkg::REG_COUNT
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Watched pins
	input wire logic reg_select_n_i,
	input wire logic sram_select_n_i,
	input wire logic out_enable_n_i,
	input wire logic write_n_i,
	input wire logic power_fail_i,
	input wire logic byte_lines_oe_o,
	input wire logic sram_bank_select_n_o,
	input wire logic sram_write_n_o,
	input wire logic sram_read_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_drive_cause: assert property ($rose(byte_lines_oe_o) |->
		$past(!reg_select_n_i && !out_enable_n_i && write_n_i, 2))
		else $error("drive without read cycle");
	chk_select_release: assert property (reg_select_n_i[*5] |=>
		!byte_lines_oe_o) else $error("drive without select");
	chk_write_release: assert property ((!write_n_i)[*5] |=>
		!byte_lines_oe_o) else $error("drive during write");
	chk_fail_block: assert property (power_fail_i[*5] |=>
		!byte_lines_oe_o && sram_bank_select_n_o)
		else $error("access under power fail");
	chk_sram_route: assert property ((!sram_select_n_i &&
		reg_select_n_i && !power_fail_i)[*5] |=> !sram_bank_select_n_o)
		else $error("sram not selected");
	chk_sram_strobe: assert property ((!sram_select_n_i &&
		reg_select_n_i && !power_fail_i && !write_n_i)[*5] |=>
		!sram_write_n_o) else $error("sram write not issued");
	chk_sram_idle: assert property (sram_select_n_i[*5] |=>
		sram_bank_select_n_o) else $error("sram selected idle");
	chk_sram_write: assert property (!sram_write_n_o |->
		!sram_bank_select_n_o) else $error("sram write unselected");
	chk_read_write: assert property (!sram_read_n_o |->
		sram_write_n_o) else $error("sram read and write");
endmodule : rbhp_port_monitor

// ===== bench/rbhp_host.sv
// Host model driving the strobes of the byte-wide port.
module rbhp_host
(
	input wire logic clk_i,
	input wire logic oe_i,
	input wire logic [7:0] bus_i,
	output logic sel_n_o,
	output logic ext_n_o,
	output logic oe_n_o,
	output logic wr_n_o,
	output logic [3:0] idx_o,
	output logic [7:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Bus cycles
	// ----
	initial
	begin
		{sel_n_o, ext_n_o, oe_n_o, wr_n_o} = 4'hf;
		idx_o = 4'h0;
		dat_o = 8'h00;
	end
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	// A released bus shows the inverse of the last byte, never a stale copy.
	task idle;
		{sel_n_o, ext_n_o, oe_n_o, wr_n_o} = 4'hf;
		dat_o = ~dat_o;
		step(5);
	endtask : idle
	task wr(input logic [3:0] a, input logic [7:0] d, input bit tog);
		idx_o = a;
		if (tog)
		begin
			dat_o = d;
			oe_n_o = 1'b0;
			sel_n_o = 1'b0;
			wr_n_o = 1'b0;
		end
		else
		begin
			sel_n_o = 1'b0;
			step(3);
			dat_o = d;
			wr_n_o = 1'b0;
		end
		step(9);
		wr_n_o = 1'b1;
		step(3);
		idle();
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] q, output bit ok);
		idx_o = a;
		sel_n_o = 1'b0;
		oe_n_o = 1'b0;
		ok = 1'b0;
		for (int i = 0; i < rbhp_pkg::ADDR_ACCESS_CYC && !ok; i++)
		begin
			step(1);
			ok = oe_i;
		end
		q = bus_i;
		idle();
	endtask : rd
	// Write opened inside a driving read; the device must free the bus.
	task rmw(input logic [3:0] a, input logic [7:0] d, output logic mid,
		output logic [7:0] q);
		idx_o = a;
		sel_n_o = 1'b0;
		oe_n_o = 1'b0;
		step(6);
		dat_o = d;
		wr_n_o = 1'b0;
		step(9);
		mid = oe_i;
		wr_n_o = 1'b1;
		step(8);
		q = bus_i;
		idle();
	endtask : rmw
	task sram(input bit w);
		ext_n_o = 1'b0;
		if (w)
			wr_n_o = 1'b0;
		else
			oe_n_o = 1'b0;
		step(6);
	endtask : sram
endmodule : rbhp_host

// ===== bench/rbhp_port_bench.sv
// Self-checking bench for the byte-wide host port.
module rbhp_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic pf = 1'b0;
	logic seen = 1'b0;
	logic sel_n, ext_n, oe_n, wr_n, oe_o, bsel_n, swr_n, srd_n;
	logic [3:0] idx;
	logic [7:0] hdat, dev_q, bus, q;
	int bad_count = 0;
	int compares = 0;
	bit ok;
	logic mid;
	assign bus = (oe_o === 1'b1) ? dev_q : hdat;
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (oe_o === 1'b1) seen <= 1'b1;
	rbhp_port i_rbhp_port (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.reg_select_n_i(sel_n), .sram_select_n_i(ext_n),
		.out_enable_n_i(oe_n), .write_n_i(wr_n), .register_index_i(idx),
		.byte_lines_i(bus), .byte_lines_o(dev_q), .byte_lines_oe_o(oe_o),
		.power_fail_i(pf), .sram_bank_select_n_o(bsel_n),
		.sram_write_n_o(swr_n), .sram_read_n_o(srd_n));
	rbhp_host i_rbhp_host (.clk_i(clk_i), .oe_i(oe_o), .bus_i(bus),
		.sel_n_o(sel_n), .ext_n_o(ext_n), .oe_n_o(oe_n), .wr_n_o(wr_n),
		.idx_o(idx), .dat_o(hdat));
	// ----
	// Checks
	// ----
	task summarize;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task check(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task rd_chk(input logic [3:0] a, input logic [7:0] e);
		i_rbhp_host.rd(a, q, ok);
		if (!ok)
		begin
			bad_count++;
			$display("BAD read wait expected 1 seen 0");
			summarize();
		end
		check("read", e, q);
	endtask : rd_chk
	task t_regs;
		for (int i = 0; i < 16; i++)
			i_rbhp_host.wr(4'(i), {4'(i), ~4'(i)}, 1'b0);
		for (int i = 0; i < 16; i++)
			rd_chk(4'(i), {4'(i), ~4'(i)});
	endtask : t_regs
	task t_together;
		seen = 1'b0;
		i_rbhp_host.wr(4'h5, 8'h3c, 1'b1);
		check("drive", 8'h00, {7'h00, seen});
		rd_chk(4'h5, 8'h3c);
	endtask : t_together
	task t_pfail;
		pf = 1'b1;
		i_rbhp_host.step(5);
		i_rbhp_host.wr(4'h2, 8'ha5, 1'b0);
		i_rbhp_host.rd(4'h2, q, ok);
		check("fail drive", 8'h00, {7'h00, ok});
		i_rbhp_host.sram(1'b1);
		check("fail sram", 8'h01, {7'h00, bsel_n});
		i_rbhp_host.idle();
		pf = 1'b0;
		i_rbhp_host.step(5);
		rd_chk(4'h2, 8'h2d);
	endtask : t_pfail
	task t_sram;
		for (int w = 0; w < 2; w++)
		begin
			i_rbhp_host.sram(w[0]);
			check("bank", 8'h00, {7'h00, bsel_n});
			check("swr", {7'h00, ~w[0]}, {7'h00, swr_n});
			check("srd", {7'h00, w[0]}, {7'h00, srd_n});
			check("oe", 8'h00, {7'h00, oe_o});
			i_rbhp_host.idle();
		end
	endtask : t_sram
	task t_busy;
		i_rbhp_host.rmw(4'h9, 8'h5a, mid, q);
		check("write release", 8'h00, {7'h00, mid});
		check("reread", 8'h5a, q);
		rd_chk(4'h9, 8'h5a);
	endtask : t_busy
	task t_reset;
		rst_b_i = 1'b0;
		i_rbhp_host.step(2);
		rst_b_i = 1'b1;
		i_rbhp_host.step(6);
		rd_chk(4'h7, rbhp_pkg::REG_RESET);
	endtask : t_reset
	initial
	begin
		repeat (4) @(posedge clk_i);
		#1;
		rst_b_i = 1'b1;
		i_rbhp_host.step(6);
		t_regs();
		t_together();
		t_pfail();
		t_sram();
		t_busy();
		t_reset();
		summarize();
	end
endmodule : rbhp_port_bench
bind rbhp_port rbhp_port_monitor #(.REG_COUNT(REG_COUNT)) i_rbhp_port_monitor
(
	.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_select_n_i(reg_select_n_i),
	.sram_select_n_i(sram_select_n_i), .out_enable_n_i(out_enable_n_i),
	.write_n_i(write_n_i), .power_fail_i(power_fail_i),
	.byte_lines_oe_o(byte_lines_oe_o),
	.sram_bank_select_n_o(sram_bank_select_n_o),
	.sram_write_n_o(sram_write_n_o), .sram_read_n_o(sram_read_n_o)
);
